// File: design/tlr_pkg.sv
// Purpose: shared constants for the trip latch and reset block
// Assumes: one clock domain, 16-bit command words
// Notes:   trip cause vector width and alarm code width are fixed here
package tlr_pkg;
  localparam int unsigned TRIP_W      = 8;
  localparam int unsigned CMD_W       = 16;
  localparam int unsigned RESET_BIT   = 7;
  localparam int unsigned ALARM_W     = 4;
  localparam int unsigned MODE_W      = 2;
  localparam logic [TRIP_W-1:0]  TRIP_NONE  = 8'h00;
  localparam logic [ALARM_W-1:0] ALARM_NONE = 4'h0;

  // sequencing mode selects which command word may reset a trip
  typedef enum logic [1:0] {
    TLR_SEQ_LOCAL    = 2'b00,
    TLR_SEQ_TERMINAL = 2'b01,
    TLR_SEQ_COMMS    = 2'b10
  } tlr_seq_t;
endpackage

// File: design/tlr_sync.sv
// Purpose: two flip-flop synchroniser for a bus of asynchronous levels
// Assumes: bits are independent levels
// Notes:   first stage is read only by the second stage
`timescale 1ns/10ps
`default_nettype none
module tlr_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: design/tlr_top.sv
// Purpose: latch drive trips, gate the power stage and handle trip reset
// Assumes: trip causes, stop key and mode are asynchronous levels; command words on clock
// Notes:   power stage enable drops in the cycle after a synchronised trip is seen
//
// Summary of operation
// - any trip condition drops the power stage enable on the third clock edge (two sync stages, then the register), motor coasts
// - a detected trip stays latched until reset, even after the fault disappears
// - power stage stays disabled while any latched trip is uncleared
// - reset is ignored for trips whose fault is still active
// - stop key press clears latched trips and removes the keypad alarm
// - terminal mode: rising edge of terminal word bit 7 clears trips
// - comms mode: rising edge of network word bit 7 clears trips
// - detected trip shows its alarm on the local keypad display
`timescale 1ns/10ps
`default_nettype none
module tlr_top (
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic [tlr_pkg::TRIP_W-1:0]    trip_cause,
  input  wire logic                          run_request,
  input  wire logic                          stop_key,
  input  wire logic [1:0]                    seq_mode,
  input  wire logic [tlr_pkg::CMD_W-1:0]     terminal_cmd_word,
  input  wire logic [tlr_pkg::CMD_W-1:0]     network_cmd_word,
  output logic                               power_enable,
  output logic [tlr_pkg::TRIP_W-1:0]         trip_latched,
  output logic                               tripped,
  output logic                               local_keypad_alarm,
  output logic [tlr_pkg::ALARM_W-1:0]        local_keypad_alarm_code
);
  // synchronised pin levels
  logic [tlr_pkg::TRIP_W-1:0]  cause_s;
  logic                        stop_s;
  logic [tlr_pkg::MODE_W-1:0]  mode_s;
  tlr_pkg::tlr_seq_t           mode;
  // previous-cycle copies for edge detection
  logic                        term_bit_q;
  logic                        net_bit_q;
  logic                        stop_q;
  // current reset bits of the command words
  logic                        term_bit;
  logic                        net_bit;
  // one-cycle edge pulses
  logic                        term_rise;
  logic                        net_rise;
  logic                        stop_press;
  // mode decode
  logic                        term_sel;
  logic                        net_sel;
  logic                        reset_req;
  // next trip vector and its summary
  logic [tlr_pkg::TRIP_W-1:0]  clr_mask;
  logic [tlr_pkg::TRIP_W-1:0]  trip_d;
  logic                        any_trip;
  logic                        enable_d;
  logic [tlr_pkg::ALARM_W-1:0] code_d;

  // trip causes come from protection circuits outside the clock domain
  tlr_sync #(
    .W (tlr_pkg::TRIP_W)
  ) u_sync_cause (
    .clock (clock),
    .rst_n (rst_n),
    .din   (trip_cause),
    .dout  (cause_s)
  );

  // stop key is a raw keypad level
  tlr_sync #(
    .W (1)
  ) u_sync_stop (
    .clock (clock),
    .rst_n (rst_n),
    .din   (stop_key),
    .dout  (stop_s)
  );

  // mode may be changed by the operator at any time
  tlr_sync #(
    .W (tlr_pkg::MODE_W)
  ) u_sync_mode (
    .clock (clock),
    .rst_n (rst_n),
    .din   (seq_mode),
    .dout  (mode_s)
  );

  // codes outside the enum fall back to local control in the decode below
  assign mode = tlr_pkg::tlr_seq_t'(mode_s);

  // reset bits of the command words
  assign term_bit = terminal_cmd_word[tlr_pkg::RESET_BIT];
  assign net_bit  = network_cmd_word[tlr_pkg::RESET_BIT];

  // copies reset low to match the idle bit, so no false edge follows reset
  // terminal bit copy
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      term_bit_q <= 1'b0;
    end else begin
      term_bit_q <= term_bit;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      net_bit_q <= 1'b0;
    end else begin
      net_bit_q <= net_bit;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= stop_s;
    end
  end

  // rising edges only
  // a bit held high gives one pulse, then nothing until it falls
  assign term_rise  = term_bit & ~term_bit_q;
  assign net_rise   = net_bit & ~net_bit_q;
  assign stop_press = stop_s & ~stop_q;

  // command word selected by the sequencing mode
  always_comb begin
    term_sel = 1'b0;
    net_sel  = 1'b0;
    unique case (mode)
      tlr_pkg::TLR_SEQ_LOCAL: begin
        term_sel = 1'b0;
        net_sel  = 1'b0;
      end
      tlr_pkg::TLR_SEQ_TERMINAL: begin
        term_sel = 1'b1;
        net_sel  = 1'b0;
      end
      tlr_pkg::TLR_SEQ_COMMS: begin
        term_sel = 1'b0;
        net_sel  = 1'b1;
      end
      default: begin
        term_sel = 1'b0;
        net_sel  = 1'b0;
      end
    endcase
  end

  assign reset_req = stop_press
                   | (term_sel & term_rise)
                   | (net_sel & net_rise);

  generate
    for (genvar g = 0; g < tlr_pkg::TRIP_W; g++) begin : g_cause
      assign clr_mask[g] = reset_req & ~cause_s[g];
      assign trip_d[g]   = cause_s[g] | (trip_latched[g] & ~clr_mask[g]);
    end
  endgenerate

  assign any_trip = |trip_d;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trip_latched <= tlr_pkg::TRIP_NONE;
    end else begin
      trip_latched <= trip_d;
    end
  end

  // trip summary
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tripped <= 1'b0;
    end else begin
      tripped <= any_trip;
    end
  end

  // enable looks at the next trip vector, so it falls on the edge the trip latches
  // disable on any trip
  assign enable_d = run_request & ~any_trip;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_enable <= 1'b0;
    end else begin
      power_enable <= enable_d;
    end
  end

  always_comb begin
    code_d = tlr_pkg::ALARM_NONE;
    for (int i = tlr_pkg::TRIP_W - 1; i >= 0; i--) begin
      if (trip_d[i]) begin
        code_d = tlr_pkg::ALARM_W'(i + 1);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      local_keypad_alarm <= 1'b0;
    end else begin
      local_keypad_alarm <= any_trip;
    end
  end

  // alarm code register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      local_keypad_alarm_code <= tlr_pkg::ALARM_NONE;
    end else begin
      local_keypad_alarm_code <= code_d;
    end
  end
endmodule
`default_nettype wire

// File: tb/tlr_host.sv
// Purpose: command word source for the reset tests
// Assumes: req bit 0 drives terminal, bit 1 network
// Notes:   bits other than 7 change every cycle
`timescale 1ns/10ps
`default_nettype none
module tlr_host (
  input  wire logic        clock,
  input  wire logic [1:0]  req,
  output logic      [15:0] term_w = 16'h0000,
  output logic      [15:0] net_w = 16'h0000
);
  logic [1:0] req_q = 2'h0;
  // request taken on the rising edge, so the falling-edge update never races the bench
  always @(posedge clock) req_q <= req;
  always @(negedge clock) begin
    term_w <= {8'($urandom), req_q[0], 7'($urandom)};
    net_w  <= {8'($urandom), req_q[1], 7'($urandom)};
  end
endmodule
`default_nettype wire

// File: tb/tlr_top_sva.sv
// Purpose: port checker for the trip latch
// Assumes: pins change off the rising edge
// Notes:   windows allow for the synchroniser stages
`timescale 1ns/10ps
`default_nettype none
module tlr_top_sva (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [7:0]  trip_cause,
  input wire logic        stop_key,
  input wire logic [1:0]  seq_mode,
  input wire logic [15:0] terminal_cmd_word,
  input wire logic [15:0] network_cmd_word,
  input wire logic        power_enable,
  input wire logic [7:0]  trip_latched,
  input wire logic        tripped,
  input wire logic        local_keypad_alarm,
  input wire logic [3:0]  local_keypad_alarm_code
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence quiet_s(logic [1:0] m);
    (trip_cause == 8'h00 && seq_mode == m)[*3];
  endsequence
  trip_power_a: assert property ($rose(|trip_cause) |-> ##[2:3] (tripped && !power_enable))
    else $error("trip did not drop enable");
  locked_out_a: assert property (|trip_latched |-> !power_enable)
    else $error("enable with trip latched");
  trip_hold_a: assert property ((!stop_key && seq_mode == 2'h0 && tripped)[*3] |=> tripped)
    else $error("trip lost without reset");
  refuse_clear_a: assert property (trip_cause[0][*3] |=> trip_latched[0])
    else $error("active trip cleared");
  alarm_show_a: assert property (local_keypad_alarm == (|trip_latched) && tripped == (|trip_latched))
    else $error("alarm does not follow trip");
  stop_clear_a: assert property (((trip_cause == 8'h00)[*3] ##0 $rose(stop_key)) |-> ##[2:4] trip_latched == 8'h00)
    else $error("stop key did not clear");
  term_clear_a: assert property (quiet_s(2'h1) ##0 $rose(terminal_cmd_word[7]) |=> trip_latched == 8'h00)
    else $error("terminal edge did not clear");
  comms_clear_a: assert property (quiet_s(2'h2) ##0 $rose(network_cmd_word[7]) |=> trip_latched == 8'h00)
    else $error("network edge did not clear");
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Purpose: random trip and reset sequences for tlr_top
// Assumes: inputs driven on the falling edge
// Notes:   waits follow the fixed latencies of the block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock = 1'b0, rst_n = 1'b0, stop_key = 1'b0, run = 1'b1, pe, tr, al;
  logic [7:0] trip_cause = 8'h00, c, tl;
  logic [1:0] seq_mode = 2'h0, req = 2'h0;
  logic [15:0] tw, nw;
  logic [3:0] cd;
  int errors = 0, num_checks = 0;
  initial forever #2.5 clock = ~clock;
  tlr_host u_tlr_host (.clock(clock), .req(req), .term_w(tw), .net_w(nw));
  tlr_top u_tlr_top (.clock(clock), .rst_n(rst_n), .trip_cause(trip_cause), .run_request(run),
    .stop_key(stop_key), .seq_mode(seq_mode), .terminal_cmd_word(tw), .network_cmd_word(nw),
    .power_enable(pe), .trip_latched(tl), .tripped(tr), .local_keypad_alarm(al), .local_keypad_alarm_code(cd));
  function automatic logic [3:0] code_of(logic [7:0] v);
    code_of = 4'h0;
    for (int i = 7; i >= 0; i--) if (v[i]) code_of = 4'(i + 1);
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin errors++; $display("ERROR %0t got %h exp %h", $time, got, exp); end
  endtask
  task automatic cyc(int n); repeat (n) @(negedge clock); endtask
  task conclude;
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    c = 8'($urandom(36));
    cyc(4); rst_n = 1'b1; cyc(3);
    chk(pe, 1'b1);
    run = 1'b0; cyc(2);
    chk(pe, 1'b0);
    run = 1'b1;
    for (int k = 0; k < 6; k++) begin
      int m;
      m = k % 3;
      c = (k == 0) ? 8'h81 : 8'($urandom_range(255, 1));
      seq_mode = 2'(m); trip_cause = c; cyc(4);
      stop_key = 1'b1; req = 2'h3; cyc(4);
      chk(tl, c);
      trip_cause = 8'h00; stop_key = 1'b0; req = 2'h0; cyc(5);
      chk({pe, tr, al}, 3'h3);
      chk(cd, code_of(c));
      req = ~2'(m); cyc(4);
      chk(tl, c);
      req = 2'h0; cyc(2);
      if (m == 0) stop_key = 1'b1; else req = 2'(m);
      cyc(5);
      chk({pe, tr, al, cd}, 7'h40);
      trip_cause = c; cyc(4); trip_cause = 8'h00; cyc(6);
      chk(tl, c);
      stop_key = 1'b0; req = 2'h0; cyc(2); stop_key = 1'b1; cyc(5); stop_key = 1'b0;
    end
    conclude();
  end
endmodule
bind tlr_top tlr_top_sva u_sva (.clock, .rst_n, .trip_cause, .stop_key, .seq_mode, .terminal_cmd_word,
  .network_cmd_word, .power_enable, .trip_latched, .tripped, .local_keypad_alarm, .local_keypad_alarm_code);
`default_nettype wire
